// file: rtl/keybuf_pkg.sv
/*
 * Shared constants for the keystroke buffer: widths, depths, register map,
 * status field positions, message key indices, reset values, detector states.
 * Assumes a 10 MHz APB clock and keyboard pins that are asynchronous to it.
 */
// How it works
// - output-hold keystroke stops codes flowing downstream; downstream drains its own memory
// - shifted call keystroke re-enables buffer output so stored codes resume
// - shifted identifier keystroke drives active-low purge that clears every storage stage
// - while output is off, keystrokes are still stored but not offered
// - a delivered code leaves storage; nothing recirculates
// - each message key stores one special code in one location
// - message keys never auto-repeat; one press gives one code
// - break function bypasses storage, works only while output is enabled
// - entries are eight bits wide, built from two four-bit slices in parallel
// - capacity is 64 entries, or 128 with the extended build
// - a code is written on each rising edge of the encoder strobe
// - each transition of the downstream enable while output is enabled moves exactly one stored code out
// - codes queue at the output in arrival order, gaps closed up
// - full drives input-ready low for as long as no location is empty
// - data-available is high when a code is stored and output is enabled
// - gating flip-flop set by shift with auxiliary forces data-available low
// - shift with call resets the gating flip-flop; downstream then drains everything
// - a special code at the output starts its sequencer instead of a character
// - control acts only when pressed after shift and released before shift
// - code output lines float whenever buffer output is disabled
package keybuf_pkg;

    localparam int KEY_W      = 7;
    localparam int CODE_W     = 8;
    localparam int SLICE_W    = 4;
    localparam int SLICES     = 2;
    localparam int BASE_DEPTH = 64;
    localparam int EXT_DEPTH  = 128;
    localparam int PTR_W      = 7;
    localparam int CNT_W      = 8;

    // synchroniser bit positions
    localparam int SY_CODE   = 0;
    localparam int SY_STROBE = 7;
    localparam int SY_SHIFT  = 8;
    localparam int SY_MSG    = 9;
    localparam int SY_BRK    = 13;
    localparam int SY_ENABLE = 14;
    localparam int SYNC_W    = 15;

    // message key indices
    localparam int MSG_KEYS  = 4;
    localparam int MSG_TEST  = 0;
    localparam int MSG_IDENT = 1;
    localparam int MSG_CALL  = 2;
    localparam int MSG_AUX   = 3;
    localparam logic [CODE_W-1:0] SPECIAL_FLAG = 8'h80;

    // register map
    localparam logic [11:0] CTRL_OFFS   = 12'h000;
    localparam logic [11:0] STATUS_OFFS = 12'h004;
    localparam logic [11:0] HEAD_OFFS   = 12'h008;
    localparam int CTRL_HOLD_BIT    = 0;
    localparam int CTRL_RELEASE_BIT = 1;
    localparam int CTRL_PURGE_BIT   = 2;
    localparam int ST_COUNT_LSB     = 0;
    localparam int ST_FULL_BIT      = 8;
    localparam int ST_EMPTY_BIT     = 9;
    localparam int ST_GATE_BIT      = 10;
    localparam int ST_EXT_BIT       = 11;

    // reset values
    localparam logic              GATE_RST   = 1'b0;
    localparam logic [31:0]       PRDATA_RST = 32'h0000_0000;
    localparam logic [CODE_W-1:0] CODE_RST   = 8'h00;

    typedef enum logic {ctl_idle, ctl_armed} ctl_state_e;

endpackage

// file: rtl/pin_sync.sv
/*
 * Two-flop synchroniser, one per bit, for keyboard pins.
 * Assumes inputs are asynchronous levels; only the second flop is read.
 */
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // pins in, synchronised out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] sync_a_q;
    logic [W-1:0] sync_b_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync_a_q[i] <= 1'b0;
                sync_b_q[i] <= 1'b0;
            end else begin
                sync_a_q[i] <= pin_in[i];
                sync_b_q[i] <= sync_a_q[i];
            end
        end
    end

    assign pin_out = sync_b_q;
endmodule

// file: rtl/fifo_slice.sv
/*
 * One four-bit-wide storage slice addressed by write and read pointers.
 * Assumes pointers are managed by the parent; purge clears every stage.
 */
`timescale 1ns/100ps
module fifo_slice
    import keybuf_pkg::*;
#(
    parameter int DEPTH = 128
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               purge_n,
    // write side
    input  wire logic               wr_en,
    input  wire logic [PTR_W-1:0]   wr_ptr,
    input  wire logic [SLICE_W-1:0] wr_nib,
    // read side
    input  wire logic [PTR_W-1:0]   rd_ptr,
    output logic      [SLICE_W-1:0] rd_nib
);
    logic [SLICE_W-1:0] mem_q [DEPTH];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
        end else if (!purge_n) begin
            for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
        end else if (wr_en) begin
            mem_q[wr_ptr] <= wr_nib;
        end
    end

    assign rd_nib = mem_q[rd_ptr];
endmodule

// file: rtl/keystroke_fifo_buffer.sv
/*
 * Keystroke buffer between the key encoder pins and the character logic,
 * with an APB register port for software control and status.
 * Assumes keyboard pins are asynchronous to pclk and the downstream logic
 * toggles its enable line once per code it wants; pready is always high.
 */
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
module keystroke_fifo_buffer #(
    parameter bit extended_memory = 1'b0
) (
    // clock and reset
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    // apb slave
    input  wire logic [11:0]                     paddr,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [31:0]                     pwdata,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // key encoder and keyswitch pins
    input  wire logic [keybuf_pkg::KEY_W-1:0]    key_code_lines,
    input  wire logic                            encoder_strobe,
    input  wire logic                            shift_key,
    input  wire logic                            test_message_key,
    input  wire logic                            identifier_key,
    input  wire logic                            call_key,
    input  wire logic                            aux_key,
    input  wire logic                            line_break_function,
    // downstream character logic
    input  wire logic                            logic_enable,
    output logic                                 data_available,
    output logic      [keybuf_pkg::CODE_W-1:0]   key_code_out,
    output logic                                 key_code_oe,
    output logic                                 code_valid,
    output logic      [keybuf_pkg::MSG_KEYS-1:0] seq_start,
    output logic                                 break_out,
    output logic                                 input_ready
);
    import keybuf_pkg::*;

    localparam int CAP = extended_memory ? EXT_DEPTH : BASE_DEPTH;
    localparam logic [CNT_W-1:0] CAP_CNT  = CNT_W'(CAP);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(CAP - 1);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [SYNC_W-1:0]   sync_in;
    logic [SYNC_W-1:0]   sy;
    logic [MSG_KEYS-1:0] msg_now;
    logic                shift_now;

    assign sync_in = {logic_enable, line_break_function, aux_key, call_key,
                      identifier_key, test_message_key, shift_key,
                      encoder_strobe, key_code_lines};

    pin_sync #(
        .W(SYNC_W)
    ) u_sync (
        .pclk   (pclk),
        .presetn(presetn),
        .pin_in (sync_in),
        .pin_out(sy)
    );

    assign msg_now   = sy[SY_MSG +: MSG_KEYS];
    assign shift_now = sy[SY_SHIFT];

    ////////////////////////////////////////////////////////////////////////
    // edge history

    logic                strobe_q;
    logic                enable_q;
    logic [MSG_KEYS-1:0] msg_q;
    logic                strobe_rise;
    logic                enable_edge;
    logic [MSG_KEYS-1:0] msg_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_q <= 1'b0;
            enable_q <= 1'b0;
            msg_q    <= '0;
        end else begin
            strobe_q <= sy[SY_STROBE];
            enable_q <= sy[SY_ENABLE];
            msg_q    <= msg_now;
        end
    end

    assign strobe_rise = sy[SY_STROBE] & ~strobe_q;
    assign enable_edge = sy[SY_ENABLE] ^ enable_q;
    assign msg_rise    = msg_now & ~msg_q;

    ////////////////////////////////////////////////////////////////////////
    // control keystroke detector

    ctl_state_e ctl_q;
    ctl_state_e ctl_d;
    logic [1:0] armed_q;
    logic [1:0] armed_d;
    logic       msg_ev;
    logic [1:0] msg_idx;
    logic       fire;
    logic [1:0] fire_idx;
    logic       fire_ident;
    logic       fire_call;
    logic       fire_aux;

    always_comb begin
        ctl_d    = ctl_q;
        armed_d  = armed_q;
        msg_ev   = 1'b0;
        msg_idx  = '0;
        fire     = 1'b0;
        fire_idx = armed_q;
        unique case (ctl_q)
            ctl_idle: begin
                for (int k = MSG_KEYS - 1; k >= 0; k--) begin
                    if (msg_rise[k]) begin
                        if (shift_now && k != MSG_TEST) begin
                            ctl_d   = ctl_armed;
                            armed_d = 2'(k);
                            msg_ev  = 1'b0;
                        end else begin
                            ctl_d   = ctl_idle;
                            msg_ev  = 1'b1;
                            msg_idx = 2'(k);
                        end
                    end
                end
            end
            ctl_armed: begin
                if (!shift_now) begin
                    // shift let go first: the key counts as an ordinary press
                    ctl_d   = ctl_idle;
                    msg_ev  = 1'b1;
                    msg_idx = armed_q;
                end else if (!msg_now[armed_q]) begin
                    ctl_d = ctl_idle;
                    fire  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q   <= ctl_idle;
            armed_q <= '0;
        end else begin
            ctl_q   <= ctl_d;
            armed_q <= armed_d;
        end
    end

    assign fire_ident = fire && fire_idx == 2'(MSG_IDENT);
    assign fire_call  = fire && fire_idx == 2'(MSG_CALL);
    assign fire_aux   = fire && fire_idx == 2'(MSG_AUX);

    ////////////////////////////////////////////////////////////////////////
    // apb slave

    logic              apb_wr;
    logic              apb_rd_setup;
    logic              addr_ok;
    logic              sw_hold;
    logic              sw_release;
    logic              sw_purge;
    logic [31:0]       prdata_q;
    logic [31:0]       rd_mux;
    logic [CNT_W-1:0]  count_q;
    logic              gate_q;
    logic              full;
    logic              empty;
    logic [CODE_W-1:0] head;

    assign addr_ok      = paddr == CTRL_OFFS || paddr == STATUS_OFFS || paddr == HEAD_OFFS;
    assign apb_wr       = psel & penable & pwrite & paddr == CTRL_OFFS;
    assign apb_rd_setup = psel & ~penable & ~pwrite;
    assign sw_hold      = apb_wr & pwdata[CTRL_HOLD_BIT];
    assign sw_release   = apb_wr & pwdata[CTRL_RELEASE_BIT];
    assign sw_purge     = apb_wr & pwdata[CTRL_PURGE_BIT];

    always_comb begin
        rd_mux = '0;
        if (paddr == CTRL_OFFS) begin
            rd_mux[CTRL_HOLD_BIT] = gate_q;
        end else if (paddr == STATUS_OFFS) begin
            rd_mux[ST_COUNT_LSB +: CNT_W] = count_q;
            rd_mux[ST_FULL_BIT]           = full;
            rd_mux[ST_EMPTY_BIT]          = empty;
            rd_mux[ST_GATE_BIT]           = gate_q;
            rd_mux[ST_EXT_BIT]            = extended_memory;
        end else if (paddr == HEAD_OFFS) begin
            rd_mux[CODE_W-1:0] = head;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= PRDATA_RST;
        end else if (apb_rd_setup) begin
            prdata_q <= rd_mux;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    ////////////////////////////////////////////////////////////////////////
    // output gating flip-flop and purge

    logic purge_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_q <= GATE_RST;
        end else if (fire_aux || sw_hold) begin
            gate_q <= 1'b1;
        end else if (fire_call || sw_release) begin
            gate_q <= 1'b0;
        end
    end

    assign purge_n = ~(fire_ident | sw_purge);

    ////////////////////////////////////////////////////////////////////////
    // write path

    logic              spec_pend_q;
    logic [1:0]        spec_idx_q;
    logic              wr_req;
    logic [CODE_W-1:0] wr_code;
    logic              do_write;
    logic              do_read;

    // a strobe takes the slot; a message code waits one cycle for it
    assign wr_req  = strobe_rise | spec_pend_q;
    assign wr_code = strobe_rise ? {1'b0, sy[SY_CODE +: KEY_W]}
                                 : SPECIAL_FLAG | {6'h00, spec_idx_q};
    // a read in the same cycle frees the slot, so a full buffer still takes the write
    assign do_write = wr_req & (~full | do_read) & purge_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spec_pend_q <= 1'b0;
            spec_idx_q  <= '0;
        end else if (!purge_n) begin
            spec_pend_q <= 1'b0;
        end else if (msg_ev) begin
            spec_pend_q <= 1'b1;
            spec_idx_q  <= msg_idx;
        end else if (do_write && !strobe_rise) begin
            spec_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pointers and occupancy

    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;

    assign full  = count_q == CAP_CNT;
    assign empty = count_q == '0;
    assign do_read = enable_edge & ~empty & ~gate_q & purge_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else if (!purge_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (do_write) begin
                wr_ptr_q <= wr_ptr_q == LAST_PTR ? '0 : wr_ptr_q + 1'b1;
            end
            if (do_read) begin
                rd_ptr_q <= rd_ptr_q == LAST_PTR ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (!purge_n) begin
            count_q <= '0;
        end else if (do_write && !do_read) begin
            count_q <= count_q + 1'b1;
        end else if (do_read && !do_write) begin
            count_q <= count_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage: two nibble slices side by side

    for (genvar s = 0; s < SLICES; s++) begin : g_slice
        fifo_slice #(
            .DEPTH(EXT_DEPTH)
        ) u_slice (
            .pclk   (pclk),
            .presetn(presetn),
            .purge_n(purge_n),
            .wr_en  (do_write),
            .wr_ptr (wr_ptr_q),
            .wr_nib (wr_code[s*SLICE_W +: SLICE_W]),
            .rd_ptr (rd_ptr_q),
            .rd_nib (head[s*SLICE_W +: SLICE_W])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // delivery and message decode

    logic [CODE_W-1:0]   out_code_q;
    logic                code_valid_q;
    logic [MSG_KEYS-1:0] seq_start_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_code_q   <= CODE_RST;
            code_valid_q <= 1'b0;
            seq_start_q  <= '0;
        end else begin
            code_valid_q <= 1'b0;
            seq_start_q  <= '0;
            if (do_read) begin
                if (head[CODE_W-1]) begin
                    seq_start_q[head[1:0]] <= 1'b1;
                end else begin
                    out_code_q   <= head;
                    code_valid_q <= 1'b1;
                end
            end
        end
    end

    assign key_code_out   = out_code_q;
    assign code_valid     = code_valid_q;
    assign seq_start      = seq_start_q;
    assign key_code_oe    = ~gate_q;
    assign data_available = ~empty & ~gate_q;
    assign input_ready    = ~full;
    assign break_out      = sy[SY_BRK] & ~gate_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_aux_fire;
        fire_aux && !sw_release;
    endsequence
    sequence s_gated;
        gate_q && !data_available;
    endsequence
    sequence s_special_out;
        do_read && head[CODE_W-1];
    endsequence

    property p_hold;
        s_aux_fire |=> s_gated;
    endproperty
    a_hold: assert property (p_hold) else $error("hold keystroke did not gate");

    property p_release;
        fire_call && !sw_hold && !fire_aux |=> !gate_q;
    endproperty
    a_release: assert property (p_release) else $error("call did not release");

    property p_purge;
        !purge_n |=> count_q == '0 && empty;
    endproperty
    a_purge: assert property (p_purge) else $error("purge left codes");

    property p_pop;
        do_read && !do_write && purge_n |=> count_q == $past(count_q) - 8'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("read did not remove code");

    property p_write;
        strobe_rise && !full && purge_n && !do_read |=> count_q == $past(count_q) + 8'h01;
    endproperty
    a_write: assert property (p_write) else $error("strobe did not store");

    property p_swap;
        do_read && do_write && purge_n |=> count_q == $past(count_q);
    endproperty
    a_swap: assert property (p_swap) else $error("write with read lost a code");

    property p_full;
        full |-> !input_ready && count_q == CAP_CNT;
    endproperty
    a_full: assert property (p_full) else $error("full not shown");

    property p_avail;
        count_q != '0 && !gate_q |-> data_available;
    endproperty
    a_avail: assert property (p_avail) else $error("stored code not offered");

    property p_special;
        s_special_out |=> seq_start != '0 && !code_valid;
    endproperty
    a_special: assert property (p_special) else $error("message code not decoded");

    property p_float;
        gate_q |-> !key_code_oe && !break_out;
    endproperty
    a_float: assert property (p_float) else $error("outputs driven while off");

endmodule

// file: sim/char_logic_model.sv
/*
 * Downstream character logic: toggles its enable line to pull one code.
 * Assumes the buffer answers a request well inside the sixteen-cycle pace.
 */
`timescale 1ns/100ps
module char_logic_model (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // bench control: go drains, poke requests regardless of data-available
    input  wire logic go,
    input  wire logic poke,
    // buffer side
    input  wire logic data_available,
    output logic      logic_enable
);
    logic [3:0] pace_q;

    // one transition, then quiet until the pace counter wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            logic_enable <= 1'b0;
            pace_q       <= 4'h0;
        end else if (pace_q != 4'h0) begin
            pace_q <= pace_q + 4'h1;
        end else if (poke || (go && data_available)) begin
            logic_enable <= ~logic_enable;
            pace_q       <= 4'h1;
        end
    end
endmodule

// file: sim/keystroke_fifo_buffer_test.sv
/*
 * Self-checking bench: APB master, key pin driver, downstream model, monitor.
 * Assumes keybuf_pkg and the design files are compiled first.
 */
`timescale 1ns/100ps
module keystroke_fifo_buffer_test;
    import keybuf_pkg::*;
    localparam int DEPTH = BASE_DEPTH;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  key_code_lines, c;
    logic [3:0]  msg_keys, seq_start;
    logic [7:0]  key_code_out;
    logic        encoder_strobe, shift_key, line_break_function, logic_enable;
    logic        data_available, key_code_oe, code_valid, break_out, input_ready;
    logic        go, poke;
    logic [7:0]  got[$], exp_q[$];
    int          num_errors, cmp_count, cycles, n;
    integer      seed;

    keystroke_fifo_buffer #(.extended_memory(1'b0)) i_keystroke_fifo_buffer (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .key_code_lines(key_code_lines),
        .encoder_strobe(encoder_strobe), .shift_key(shift_key),
        .test_message_key(msg_keys[MSG_TEST]), .identifier_key(msg_keys[MSG_IDENT]),
        .call_key(msg_keys[MSG_CALL]), .aux_key(msg_keys[MSG_AUX]),
        .line_break_function(line_break_function), .logic_enable(logic_enable),
        .data_available(data_available), .key_code_out(key_code_out),
        .key_code_oe(key_code_oe), .code_valid(code_valid), .seq_start(seq_start),
        .break_out(break_out), .input_ready(input_ready));
    char_logic_model i_char_logic_model (
        .pclk(pclk), .presetn(presetn), .go(go), .poke(poke),
        .data_available(data_available), .logic_enable(logic_enable));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (code_valid === 1'b1) got.push_back(key_code_out);
        for (int i = 0; i < MSG_KEYS; i++)
            if (seq_start[i] === 1'b1) got.push_back(SPECIAL_FLAG | 8'(i));
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    function automatic logic [31:0] st_exp(input int k, input logic g);
        st_exp                = 32'h0;
        st_exp[7:0]           = 8'(k);
        st_exp[ST_FULL_BIT]   = (k == DEPTH);
        st_exp[ST_EMPTY_BIT]  = (k == 0);
        st_exp[ST_GATE_BIT]   = g;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic st(input int k, input logic g);
        apb(1'b0, STATUS_OFFS, 32'h0);
        chk(rd, st_exp(k, g));
    endtask
    task automatic type_code(input logic [6:0] v);
        @(posedge pclk);
        key_code_lines <= v;
        repeat (2) @(posedge pclk);
        encoder_strobe <= 1'b1;
        repeat (3) @(posedge pclk);
        encoder_strobe <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    // mode 0 plain, 1 shifted control, 2 shift released before the key
    task automatic press(input int k, input int mode);
        @(posedge pclk);
        shift_key <= (mode != 0);
        repeat (4) @(posedge pclk);
        msg_keys[k] <= 1'b1;
        repeat (20) @(posedge pclk);
        if (mode == 2) shift_key <= 1'b0;
        else msg_keys[k] <= 1'b0;
        repeat (4) @(posedge pclk);
        shift_key   <= 1'b0;
        msg_keys[k] <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    task automatic drain_check();
        int w;
        w = 0;
        while (got.size() < exp_q.size() && w < 3000) begin
            @(posedge pclk);
            w++;
        end
        repeat (40) @(posedge pclk);
        chk(32'(got.size()), 32'(exp_q.size()));
        foreach (exp_q[i]) chk(32'(got[i]), 32'(exp_q[i]));
        got   = {};
        exp_q = {};
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hC84BD78F;
        {psel, penable, pwrite, encoder_strobe, shift_key} = '0;
        {line_break_function, go, poke, err} = '0;
        {paddr, pwdata, rd, key_code_lines, msg_keys, c} = '0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        press(MSG_IDENT, 1);
        st(0, 1'b0);
        apb(1'b0, 12'h00C, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        poke <= 1'b1;
        @(posedge pclk);
        poke <= 1'b0;
        drain_check();
        st(0, 1'b0);
        $display("test reset done");
        press(MSG_AUX, 1);
        line_break_function <= 1'b1;
        n = 5 + ($unsigned($random(seed)) % 6);
        for (int i = 0; i < n; i++) begin
            c = (i == 0) ? 7'h7F : 7'($random(seed));
            type_code(c);
            exp_q.push_back({1'b0, c});
        end
        @(negedge pclk);
        chk({data_available, key_code_oe, break_out}, 32'h0);
        st(n, 1'b1);
        apb(1'b0, HEAD_OFFS, 32'h0);
        chk(rd, 32'h7F);
        apb(1'b0, CTRL_OFFS, 32'h0);
        chk(rd, 32'h1);
        press(MSG_CALL, 1);
        @(negedge pclk);
        chk({key_code_oe, break_out}, 32'h3);
        for (int i = 0; i < 6; i++) begin
            go <= 1'($random(seed));
            c  = 7'($random(seed));
            type_code(c);
            exp_q.push_back({1'b0, c});
        end
        go                  <= 1'b1;
        line_break_function <= 1'b0;
        drain_check();
        st(0, 1'b0);
        $display("test hold and release done");
        for (int k = 0; k < MSG_KEYS; k++) begin
            press(k, 0);
            exp_q.push_back(SPECIAL_FLAG | 8'(k));
        end
        press(MSG_AUX, 2);
        exp_q.push_back(SPECIAL_FLAG | 8'(MSG_AUX));
        drain_check();
        st(0, 1'b0);
        $display("test message keys done");
        go <= 1'b0;
        apb(1'b1, CTRL_OFFS, 32'h1);
        for (int i = 0; i <= DEPTH; i++) type_code(7'(i));
        @(negedge pclk);
        chk({31'h0, input_ready}, 32'h0);
        st(DEPTH, 1'b1);
        press(MSG_IDENT, 1);
        st(0, 1'b1);
        @(negedge pclk);
        chk({31'h0, input_ready}, 32'h1);
        apb(1'b1, CTRL_OFFS, 32'h2);
        go <= 1'b1;
        type_code(7'h55);
        exp_q.push_back(8'h55);
        drain_check();
        $display("test fill and purge done");
        print_verdict();
    end
endmodule
